/* File: hdl/kbd_link_ctrl.sv */
// Keyboard serial link controller: receive, translate, buffer and transmit bytes
`timescale 1ns/1ns
// Behaviour
// [RL1] Receive keyboard frames and check their parity
// [RL2] Translate scan codes, buffer one byte each
// [RL3] Raise interrupt when the output buffer holds data
// [RL4] Status flag shows output buffer has data
// [RL5] Send host-written bytes serially to keyboard
// [RL6] Sent bytes carry an automatic odd parity bit
// [RL7] Every byte on the link is acknowledged; a received frame with bad parity or a bad stop bit is left unacknowledged
// [RL8] No new send before previous acknowledgment
// [RL9] Buffer-full interrupt serves send and receive
// [RL10] Parity failure flagged alongside the buffered byte
module kbd_link_ctrl import kbd_pkg::*; #(
  parameter int unsigned INHIBIT_CYCLES = INHIBIT_CYC,
  parameter int unsigned BUF_DEPTH = BUF_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic kclk_i,
  output logic kclk_o,
  output logic kclk_oe,
  input wire logic kdata_i,
  output logic kdata_o,
  output logic kdata_oe,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [DATA_W-1:0] out_data,
  output logic out_parity_err,
  output logic out_valid,
  input wire logic out_ready,
  input wire logic xlate_en,
  input wire logic irq_en,
  output logic irq,
  output logic status_obf,
  output logic tx_busy,
  output logic tx_ack_err
);
  localparam int unsigned INH_W = $clog2(INHIBIT_CYCLES);
  localparam logic [INH_W-1:0] INH_LAST = INH_W'(INHIBIT_CYCLES - 1);
  localparam logic [INH_W-1:0] INH_STEP = INH_W'(1);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  link_state_t state_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic [RX_SHIFT_W-1:0] rx_shift_ff;
  logic [TX_SHIFT_W-1:0] tx_shift_ff;
  logic [INH_W-1:0] inh_cnt_ff;
  logic kclk_prev_ff;
  logic kclk_oe_ff;
  logic kdata_oe_ff;
  logic brk_ff;
  logic tx_ack_err_ff;
  logic fall;
  logic rx_start;
  logic accept;
  logic inh_done;
  logic rx_frame_end;
  logic rx_frame_bad;
  logic rx_is_prefix;
  logic [DATA_W-1:0] rx_xlated;
  logic buf_push;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic [BUF_W-1:0] buf_out_data;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= '0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // Link decode
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kclk_prev_ff <= 1'b1;
    end else begin
      kclk_prev_ff <= kclk_i;
    end
  end

  // The keyboard makes the clock; every bit except a sent byte's start bit, driven as the inhibit ends, moves on its falling edge
  assign fall = kclk_prev_ff && !kclk_i;
  assign rx_start = (state_ff == ST_IDLE) && fall && !kdata_i;
  // A keyboard frame that starts wins over a host write in the same cycle
  assign in_ready = (state_ff == ST_IDLE) && !rx_start; // see [RL8]
  assign accept = in_valid && in_ready;
  assign inh_done = (inh_cnt_ff == INH_LAST);
  assign rx_frame_end = (state_ff == ST_RX) && fall && (bit_cnt_ff == CNT_STOP);
  // Odd parity: data and parity bit together hold an odd number of ones
  assign rx_frame_bad = !(^rx_shift_ff) || !kdata_i; // see [RL1]
  assign rx_is_prefix = xlate_en && !rx_frame_bad && (rx_shift_ff[DATA_W-1:0] == BREAK_CODE); // see [RL2]
  assign rx_xlated = (xlate_en && brk_ff) ? (rx_shift_ff[DATA_W-1:0] | BREAK_MARK)
                                          : rx_shift_ff[DATA_W-1:0]; // see [RL2]
  // The clock is held low while the buffer is full, so a push always lands
  assign buf_push = rx_frame_end && !rx_is_prefix;
  assign buf_in_data = {rx_frame_bad, rx_xlated}; // see [RL10]

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= CNT_ZERO;
      rx_shift_ff <= '0;
      tx_shift_ff <= '0;
      inh_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          bit_cnt_ff <= CNT_ZERO;
          inh_cnt_ff <= '0;
          if (rx_start) begin
            state_ff <= ST_RX;
          end else if (accept) begin
            state_ff <= ST_INH; // see [RL5]
            tx_shift_ff <= {1'b1, ~(^in_data), in_data}; // see [RL6]
          end
        end
        ST_RX: begin
          if (fall) begin
            if (bit_cnt_ff == CNT_STOP) begin
              state_ff <= ST_RXACK;
            end else begin
              rx_shift_ff <= {kdata_i, rx_shift_ff[RX_SHIFT_W-1:1]};
              bit_cnt_ff <= bit_cnt_ff + CNT_STEP;
            end
          end
        end
        ST_RXACK: begin
          if (fall) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_INH: begin
          inh_cnt_ff <= inh_cnt_ff + INH_STEP;
          if (inh_done) begin
            state_ff <= ST_TX;
          end
        end
        ST_TX: begin
          if (fall) begin
            tx_shift_ff <= {1'b0, tx_shift_ff[TX_SHIFT_W-1:1]};
            bit_cnt_ff <= bit_cnt_ff + CNT_STEP;
            if (bit_cnt_ff == CNT_STOP) begin
              state_ff <= ST_TXACK;
            end
          end
        end
        ST_TXACK: begin
          // Nothing new is sent until the keyboard's acknowledge slot passes
          if (fall) begin
            state_ff <= ST_IDLE; // see [RL8]
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Line drivers
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kclk_oe_ff <= 1'b0;
    end else if (accept) begin
      kclk_oe_ff <= 1'b1; // see [RL5]
    end else if (state_ff == ST_INH) begin
      kclk_oe_ff <= !inh_done;
    end else if (state_ff == ST_IDLE) begin
      // Back-pressure: hold the keyboard off rather than drop a byte
      kclk_oe_ff <= !buf_in_ready;
    end else begin
      kclk_oe_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kdata_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_INH: begin
          if (inh_done) begin
            kdata_oe_ff <= 1'b1;
          end
        end
        ST_TX: begin
          if (fall) begin
            kdata_oe_ff <= !tx_shift_ff[0]; // see [RL5]
          end
        end
        ST_RX: begin
          // A bad frame is left unacknowledged so the keyboard repeats it
          if (rx_frame_end) begin
            kdata_oe_ff <= !rx_frame_bad; // see [RL7]
          end
        end
        ST_RXACK: begin
          if (fall) begin
            kdata_oe_ff <= 1'b0;
          end
        end
        default: begin
          kdata_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Flags
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      brk_ff <= 1'b0;
    end else if (rx_frame_end) begin
      brk_ff <= rx_is_prefix;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ack_err_ff <= 1'b0;
    end else if (accept) begin
      tx_ack_err_ff <= 1'b0;
    end else if ((state_ff == ST_TXACK) && fall) begin
      tx_ack_err_ff <= kdata_i; // see [RL7]
    end
  end

  entry_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out_data)
  );

  assign out_data = buf_out_data[DATA_W-1:0];
  assign out_parity_err = buf_out_data[ERR_POS]; // see [RL10]
  assign status_obf = out_valid; // see [RL4]
  // Keyboard replies to sent bytes land here too, so one interrupt serves both
  assign irq = out_valid && irq_en; // see [RL3] [RL9]
  assign kclk_o = 1'b0;
  assign kdata_o = 1'b0;
  assign kclk_oe = kclk_oe_ff;
  assign kdata_oe = kdata_oe_ff;
  assign tx_busy = (state_ff == ST_INH) || (state_ff == ST_TX) || (state_ff == ST_TXACK);
  assign tx_ack_err = tx_ack_err_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_RX_PARITY: assert property (buf_push |-> buf_in_data[ERR_POS] == (!(^rx_shift_ff) || !kdata_i)) // see [RL1]
    else $error("parity check result not stored with byte");
  AST_BREAK_XLATE: assert property (rx_frame_end && rx_is_prefix |=> brk_ff ##0 !out_valid || $stable(out_valid)) // see [RL2]
    else $error("break prefix not absorbed");
  AST_IRQ_ON_LOAD: assert property (buf_push && irq_en |=> ##[0:1] irq) // see [RL3]
    else $error("interrupt missing after byte loaded");
  AST_OBF_STATUS: assert property (buf_push |=> status_obf) // see [RL4]
    else $error("status flag not set after byte loaded");
  AST_TX_START: assert property (accept |=> state_ff == ST_INH ##0 kclk_oe[*8]) // see [RL5]
    else $error("send did not start with clock inhibit");
  AST_TX_PARITY: assert property (accept |=> tx_shift_ff[TX_PAR_POS] == ~(^$past(in_data))) // see [RL6]
    else $error("odd parity bit wrong");
  AST_RX_ACK: assert property (rx_frame_end && !rx_frame_bad |=> kdata_oe && state_ff == ST_RXACK) // see [RL7]
    else $error("good frame not acknowledged");
  AST_ONE_AT_A_TIME: assert property (tx_busy |-> !in_ready) // see [RL8]
    else $error("new byte taken before acknowledgment");
  AST_IRQ_HOLDS: assert property (irq && !out_ready && $stable(irq_en) |=> irq) // see [RL9]
    else $error("interrupt dropped while byte unread");

  COV_RX_BYTE: cover property (buf_push && !buf_in_data[ERR_POS]);
  COV_RX_BAD: cover property (buf_push && buf_in_data[ERR_POS]);
  COV_TX_DONE: cover property ((state_ff == ST_TXACK) && fall && !kdata_i);
  COV_FULL_HOLD: cover property ((state_ff == ST_IDLE) && !buf_in_ready && kclk_oe);

endmodule : kbd_link_ctrl

/* File: inc/kbd_pkg.sv */
// Shared constants and types for the keyboard link controller
package kbd_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RX_SHIFT_W = 9;
  localparam int unsigned TX_SHIFT_W = 10;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;
  // Index of the stop bit in a frame, counting the first data bit as 0
  localparam logic [CNT_W-1:0] CNT_STOP = 4'h9;
  localparam int unsigned TX_PAR_POS = 8;
  localparam int unsigned ERR_POS = 8;
  localparam int unsigned BUF_W = 9;

  // ==========================================================================
  // Scan code translation
  // ==========================================================================
  localparam logic [DATA_W-1:0] BREAK_CODE = 8'hf0;
  localparam logic [DATA_W-1:0] BREAK_MARK = 8'h80;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INHIBIT_US = 100;
  // Least time, so the count rounds up
  localparam int unsigned INHIBIT_CYC = (INHIBIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUF_DEPTH_DEF = 2;

  // ==========================================================================
  // Link sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_RXACK = 3'h3,
    ST_INH   = 3'h2,
    ST_TX    = 3'h6,
    ST_TXACK = 3'h7
  } link_state_t;

endpackage : kbd_pkg

/* File: hdl/entry_buffer.sv */
// Small FIFO holding received bytes until the host takes them
`timescale 1ns/1ns
module entry_buffer #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != CNT_FULL);
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // ==========================================================================
  // Storage
  // ==========================================================================
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        mem_ff[i] <= '0;
      end else if (push && (wr_ptr_ff == PTR_W'(i))) begin
        mem_ff[i] <= in_data;
      end
    end
  end

  // ==========================================================================
  // Pointers and fill level
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + PTR_ONE;
      end
      if (push && !pop) begin
        count_ff <= count_ff + CNT_ONE;
      end else if (pop && !push) begin
        count_ff <= count_ff - CNT_ONE;
      end
    end
  end

endmodule : entry_buffer

/* File: dv/kbd_model.sv */
// Behavioural keyboard that sits on the far side of the serial link
`timescale 1ns/1ns
module kbd_model (
  input wire logic clock,
  input wire logic kclk_line,
  input wire logic kdata_line,
  output logic clk_low,
  output logic data_low
);
  // Half period of the link clock, in system cycles; the bench varies it to test slow and prompt links
  int half = 4;
  logic ack_seen;

  initial begin
    clk_low = 1'b0;
    data_low = 1'b0;
    ack_seen = 1'b0;
  end

  // ==========================================================================
  // Link clock
  // ==========================================================================
  // The data line is read late in the low phase, after the controller has settled its bit
  task automatic tick(output logic s);
    repeat (half) @(negedge clock);
    clk_low = 1'b1;
    repeat (half) @(negedge clock);
    s = kdata_line;
    clk_low = 1'b0;
  endtask : tick

  // ==========================================================================
  // Keyboard to controller
  // ==========================================================================
  // A held-low clock means the controller cannot take a byte, so the frame waits
  task automatic send_frame(input logic [7:0] b, input bit bad);
    logic [10:0] bits;
    logic s;
    int n;
    bits = {1'b1, (~^b) ^ bad, b, 1'b0};
    for (n = 0; n < 5000 && kclk_line !== 1'b1; n++) @(negedge clock);
    for (n = 0; n < 11; n++) begin
      data_low = ~bits[n];
      tick(s);
    end
    data_low = 1'b0;
    // The controller lets go of its acknowledge once it sees this edge, so the slot is read as the clock falls
    repeat (half) @(negedge clock);
    clk_low = 1'b1;
    s = kdata_line;
    repeat (half) @(negedge clock);
    clk_low = 1'b0;
    // No further frame starts before this slot has been seen
    ack_seen = ~s;
  endtask : send_frame

  // ==========================================================================
  // Controller to keyboard
  // ==========================================================================
  task automatic recv_frame(input bit nak, output logic [7:0] b, output logic ok);
    logic [9:0] r;
    logic s;
    int n;
    for (n = 0; n < 5000 && !(kclk_line === 1'b1 && kdata_line === 1'b0); n++) @(negedge clock);
    for (n = 0; n < 10; n++) begin
      tick(s);
      r[n] = s;
    end
    data_low = ~nak;
    tick(s);
    data_low = 1'b0;
    b = r[7:0];
    ok = (^r[8:0]) & r[9];
  endtask : recv_frame
endmodule : kbd_model

/* File: dv/tb_kbd_link_ctrl.sv */
// Self-checking bench for the keyboard link controller
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, (exp), (got)); end end
module tb_kbd_link_ctrl;
  import kbd_pkg::*;
  localparam int unsigned INH = 16;
  localparam int LIMIT = 20000;
  logic clock, arst_n, in_valid, out_ready, xlate_en, irq_en, brk;
  logic [DATA_W-1:0] in_data, out_data, b;
  logic kclk_o, kclk_oe, kdata_o, kdata_oe, in_ready, out_parity_err, out_valid, irq, status_obf;
  logic tx_busy, tx_ack_err, kbd_clk_low, kbd_data_low;
  // Both lines are open drain with pull-ups
  wire kclk_line = ~(kclk_oe | kbd_clk_low);
  wire kdata_line = ~(kdata_oe | kbd_data_low);
  logic [8:0] exp_q[$];
  int errors, checks, cyc, seed, k;

  kbd_link_ctrl #(.INHIBIT_CYCLES(INH), .BUF_DEPTH(2)) i_kbd_link_ctrl (
    .clock(clock), .arst_n(arst_n), .kclk_i(kclk_line), .kclk_o(kclk_o), .kclk_oe(kclk_oe),
    .kdata_i(kdata_line), .kdata_o(kdata_o), .kdata_oe(kdata_oe), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_parity_err(out_parity_err),
    .out_valid(out_valid), .out_ready(out_ready), .xlate_en(xlate_en), .irq_en(irq_en), .irq(irq),
    .status_obf(status_obf), .tx_busy(tx_busy), .tx_ack_err(tx_ack_err));
  kbd_model i_kbd_model (.clock(clock), .kclk_line(kclk_line), .kdata_line(kdata_line),
    .clk_low(kbd_clk_low), .data_low(kbd_data_low));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      $display("[ERR] run length exp %0d got %0d", LIMIT - 1, cyc);
      end_sim();
    end
  end

  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Receive side and reference queue
  // ==========================================================================
  task automatic rx_byte(input logic [7:0] v, input bit bad);
    i_kbd_model.send_frame(v, bad);
    `CHK("rx_ack", ~bad, i_kbd_model.ack_seen)
    // A damaged frame is still buffered and still ends a pending break prefix
    if (!bad && xlate_en && v == BREAK_CODE) begin
      brk = 1'b1;
    end else begin
      exp_q.push_back({bad, brk ? (v | BREAK_MARK) : v});
      brk = 1'b0;
    end
    repeat (2) @(negedge clock);
    `CHK("status_obf", exp_q.size() != 0, status_obf)
  endtask : rx_byte

  task automatic pop();
    logic [8:0] e;
    e = exp_q.pop_front();
    `CHK("status_obf", 1'b1, status_obf)
    `CHK("out_valid", 1'b1, out_valid)
    `CHK("irq", irq_en, irq)
    `CHK("out_data", e[7:0], out_data)
    `CHK("out_parity_err", e[8], out_parity_err)
    out_ready = 1'b1;
    @(negedge clock);
    out_ready = 1'b0;
  endtask : pop

  // ==========================================================================
  // Send side
  // ==========================================================================
  task automatic host_write(input logic [7:0] v);
    logic ok;
    int n;
    in_data = v;
    in_valid = 1'b1;
    for (n = 0; n < 5000; n++) begin
      ok = in_ready;
      @(posedge clock);
      if (ok) break;
      @(negedge clock);
    end
    @(negedge clock);
    in_valid = 1'b0;
  endtask : host_write

  task automatic tx_check(input logic [7:0] v, input bit nak);
    logic [7:0] got;
    logic ok;
    i_kbd_model.recv_frame(nak, got, ok);
    `CHK("tx_data", v, got)
    `CHK("tx_parity", 1'b1, ok)
    repeat (2) @(negedge clock);
    `CHK("tx_ack_err", nak, tx_ack_err)
  endtask : tx_check

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 47;
    errors = 0;
    checks = 0;
    cyc = 0;
    brk = 1'b0;
    arst_n = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b0;
    xlate_en = 1'b0;
    irq_en = 1'b0;
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("status_obf", 1'b0, status_obf)
    `CHK("tx_busy", 1'b0, tx_busy)
    `CHK("kclk_o", 1'b0, kclk_o)
    `CHK("kdata_o", 1'b0, kdata_o)
    for (k = 0; k < 8; k++) begin
      irq_en = k[0];
      i_kbd_model.half = 2 + k;
      rx_byte(8'($random(seed)), ($random(seed) & 3) == 0);
      pop();
    end
    xlate_en = 1'b1;
    for (k = 0; k < 2; k++) begin
      rx_byte(BREAK_CODE, 1'b0);
      rx_byte(8'($random(seed)) & 8'h7f, 1'b0);
      pop();
    end
    rx_byte(8'h1c, 1'b0);
    pop();
    xlate_en = 1'b0;
    // Both entries full: the link must be held off, and nothing lost while the host stalls
    rx_byte(8'h5a, 1'b0);
    rx_byte(8'ha5, 1'b0);
    repeat (4) @(negedge clock);
    `CHK("kclk_oe", 1'b1, kclk_oe)
    fork
      rx_byte(8'h3c, 1'b0);
      begin
        repeat (60) @(negedge clock);
        pop();
        @(negedge clock);
        pop();
      end
    join
    pop();
    for (k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      i_kbd_model.half = 2 + 3 * k;
      host_write(b);
      `CHK("tx_busy", 1'b1, tx_busy)
      `CHK("in_ready", 1'b0, in_ready)
      tx_check(b, k == 2);
    end
    // The second write is offered at once and must wait for the first acknowledge
    b = 8'h96;
    host_write(8'h69);
    @(negedge clock);
    fork
      host_write(b);
      tx_check(8'h69, 1'b0);
    join
    tx_check(b, 1'b0);
    end_sim();
  end
endmodule : tb_kbd_link_ctrl
